// ---- rtl/vfic_defs.svh ----
// Register indices, field positions, reset values and timing for the forwarding/irq block
`ifndef VFIC_DEFS_SVH
`define VFIC_DEFS_SVH

`define VFIC_IDX_FWD_CTL_ONE  8'h20
`define VFIC_IDX_FWD_CTL_TWO  8'h21
`define VFIC_IDX_FWD_STATUS   8'h22
`define VFIC_IDX_IRQ_CTL      8'h23
`define VFIC_IDX_IRQ_STS      8'h24
`define VFIC_IDX_IRQ_CLR      8'h40

`define VFIC_BIT_BLOCK0       4
`define VFIC_BIT_REPLICATE    7
`define VFIC_BIT_AS_AVAIL     6
`define VFIC_BIT_MODE0        2
`define VFIC_BIT_INT_EN       7
`define VFIC_BIT_INT          7

`define VFIC_RST_FWD_CTL_ONE  8'hF0
`define VFIC_RST_FWD_CTL_TWO  8'h03
`define VFIC_RST_IRQ_CTL      8'h00
`define VFIC_IRQ_CTL_MASK     8'hBF
`define VFIC_HSIZE_WORD       3'h2

`define VFIC_CLK_PERIOD_NS    10
`define VFIC_SYNC_WIN_NS      1000
`define VFIC_SYNC_WIN_CYC     (`VFIC_SYNC_WIN_NS / `VFIC_CLK_PERIOD_NS)

`endif

// ---- rtl/vfic_pkg.sv ----
// Types shared by the forwarding and interrupt control block
package vfic_pkg;

  typedef enum logic [1:0] {
    VFIC_SYNC_OFF        = 2'b00,
    VFIC_SYNC_BASIC      = 2'b01,
    VFIC_SYNC_INTERLEAVE = 2'b10,
    VFIC_SYNC_CONCAT     = 2'b11
  } vfic_mode_t;

  typedef enum logic {
    VFIC_TRK_IDLE    = 1'b0,
    VFIC_TRK_COLLECT = 1'b1
  } vfic_trk_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] ports;
    logic       long_pkt;
    vfic_mode_t mode;
  } vfic_fwd_t;

endpackage : vfic_pkg

// ---- rtl/vfic_core.sv ----
// Video forwarding control, sync tracking and interrupt aggregation with AHB-Lite registers
`include "vfic_defs.svh"

module vfic_core
  import vfic_pkg::*;
#(
  parameter int ADDR_W       = 10,
  parameter int SYNC_WIN_CYC = `VFIC_SYNC_WIN_CYC
) (
  input  wire logic              hclk,            // Core clock
  input  wire logic              hresetn,         // Async reset, active low
  input  wire logic              hsel,            // Slave select
  input  wire logic [ADDR_W-1:0] haddr,           // Byte address
  input  wire logic [1:0]        htrans,          // Transfer type
  input  wire logic              hwrite,          // Write when high
  input  wire logic [2:0]        hsize,           // Transfer size
  input  wire logic [31:0]       hwdata,          // Write data
  input  wire logic              hready,          // Bus ready in
  output logic      [31:0]       hrdata,          // Read data
  output logic                   hreadyout,       // Slave ready
  output logic                   hresp,           // Always OKAY
  input  wire logic [3:0]        port_pkt_ready,  // Port has a packet waiting
  input  wire logic [3:0]        port_pkt_long,   // Waiting packet is a video line
  input  wire logic [3:0]        port_frame_end,  // Port finished a frame
  output logic      [3:0]        port_send,       // Packet taken from port
  input  wire logic [1:0]        out_accept,      // Output can take a packet
  output vfic_fwd_t              out0_fwd,        // Forward command, output 0
  output vfic_fwd_t              out1_fwd,        // Forward command, output 1
  input  wire logic [3:0]        rx_irq_event,    // Receive port raised interrupt
  input  wire logic [3:0]        rx_status_read,  // Receive port status was read
  input  wire logic [1:0]        tx_irq_event,    // Transmitter raised interrupt
  input  wire logic [1:0]        tx_isr_read,     // Transmitter status was read
  output logic                   irq              // Interrupt to controller
);

  logic [7:0] fwd_one;
  logic [7:0] next_fwd_one;
  logic [7:0] fwd_two;
  logic [7:0] next_fwd_two;
  logic [7:0] irq_ctl;
  logic [7:0] next_irq_ctl;
  logic [5:0] irq_flag;
  logic [7:0] irq_sts;
  logic [7:0] forwarding_status;
  logic [7:0] rd_val;
  logic       addr_ok;
  logic [7:0] addr_idx;
  logic       wr_pend;
  logic [7:0] wr_idx;
  logic       rd_sts;
  logic [5:0] irq_clr;

  localparam int CW = $clog2(SYNC_WIN_CYC + 1);

  function automatic logic [3:0] rr_pick(input logic [3:0] req, input logic [1:0] last);
    logic [3:0] g;
    logic [1:0] k;
    g = '0;
    for (int i = 1; i <= 4; i++) begin
      k = last + 2'(i);
      if (g == 4'h0 && req[k]) begin
        g[k] = 1'b1;
      end
    end
    return g;
  endfunction : rr_pick

  function automatic logic [1:0] enc(input logic [3:0] onehot);
    logic [1:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      if (onehot[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction : enc

  // Bus slave: never stalls, never errors
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && hready && htrans[1];
  assign addr_idx  = haddr[9:2];
  assign rd_sts    = addr_ok && !hwrite && (addr_idx == `VFIC_IDX_FWD_STATUS);
  assign irq_clr   = (wr_pend && wr_idx == `VFIC_IDX_IRQ_CLR) ? hwdata[5:0] : 6'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= 8'h00;
    end else begin
      wr_pend <= addr_ok && hwrite && (hsize == `VFIC_HSIZE_WORD);
      wr_idx  <= addr_idx;
    end
  end

  // Read mux sees the next values of the three control registers so a read right after writing one is not stale
  always_comb begin
    next_fwd_one = fwd_one;
    next_fwd_two = fwd_two;
    next_irq_ctl = irq_ctl;
    if (wr_pend && wr_idx == `VFIC_IDX_FWD_CTL_ONE) begin
      next_fwd_one = hwdata[7:0];
    end
    if (wr_pend && wr_idx == `VFIC_IDX_FWD_CTL_TWO) begin
      next_fwd_two = hwdata[7:0];
    end
    if (wr_pend && wr_idx == `VFIC_IDX_IRQ_CTL) begin
      next_irq_ctl = hwdata[7:0] & `VFIC_IRQ_CTL_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fwd_one <= `VFIC_RST_FWD_CTL_ONE;
      fwd_two <= `VFIC_RST_FWD_CTL_TWO;
      irq_ctl <= `VFIC_RST_IRQ_CTL;
    end else begin
      fwd_one <= next_fwd_one;
      fwd_two <= next_fwd_two;
      irq_ctl <= next_irq_ctl;
    end
  end

  always_comb begin
    case (addr_idx)
      `VFIC_IDX_FWD_CTL_ONE: rd_val = next_fwd_one;
      `VFIC_IDX_FWD_CTL_TWO: rd_val = next_fwd_two;
      `VFIC_IDX_FWD_STATUS:  rd_val = forwarding_status;
      `VFIC_IDX_IRQ_CTL:     rd_val = next_irq_ctl;
      `VFIC_IDX_IRQ_STS:     rd_val = irq_sts;
      default:               rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= {24'h00_0000, rd_val};
    end
  end

  // One forwarding engine per output
  for (genvar o = 0; o < 2; o++) begin : g_out
    vfic_mode_t   mode;
    logic [3:0]   elig;
    logic [3:0]   ready_e;
    logic [3:0]   grant;
    logic         sync_on;
    logic         as_ok;
    logic [1:0]   rr_ptr;
    vfic_trk_t    trk;
    logic [3:0]   pend;
    logic [3:0]   next_pend;
    logic [CW-1:0] win_cnt;
    logic         synced;
    logic         sent_one;
    logic         lost_evt;
    logic         lost_flag;
    vfic_fwd_t    next_fwd;
    logic         mode_next_on;
    logic         synced_vis;

    assign mode    = vfic_mode_t'(fwd_two[`VFIC_BIT_MODE0 + 2*o +: 2]);
    assign sync_on = (mode != VFIC_SYNC_OFF);
    assign as_ok   = fwd_two[`VFIC_BIT_AS_AVAIL] && (mode != VFIC_SYNC_CONCAT);
    assign ready_e = port_pkt_ready & elig;

    // The tracker clears a cycle late, so a status read racing a mode-off write must still see 0
    assign mode_next_on = (next_fwd_two[`VFIC_BIT_MODE0 + 2*o +: 2] != 2'b00);
    assign synced_vis   = synced && mode_next_on;

    always_comb begin
      for (int p = 0; p < 4; p++) begin
        elig[p] = !fwd_one[`VFIC_BIT_BLOCK0 + p]
                  && (fwd_one[p] == 1'(o));
      end
      // In replicate mode output 1 carries only the copy of output 0
      if (o == 1 && fwd_two[`VFIC_BIT_REPLICATE]) begin
        elig = 4'h0;
      end
    end

    // Sync wins if software sets both modes; the pair is illegal anyway
    always_comb begin
      grant = 4'h0;
      if (out_accept[o]) begin
        if (sync_on) begin
          if (elig != 4'h0 && ready_e == elig) begin
            grant = elig;
          end else if (as_ok) begin
            grant = ready_e & port_pkt_long;
          end
        end else if (fwd_two[o]) begin
          grant = rr_pick(ready_e, rr_ptr);
        end
      end
    end

    always_comb begin
      next_fwd.valid    = (grant != 4'h0);
      next_fwd.ports    = grant;
      next_fwd.long_pkt = |(grant & port_pkt_long);
      next_fwd.mode     = mode;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        rr_ptr <= 2'h3;
      end else if (!sync_on && grant != 4'h0) begin
        rr_ptr <= enc(grant);
      end
    end

    // Sync tracker: all enabled ports must end a frame within the window
    assign next_pend = pend | (port_frame_end & elig);

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        trk      <= VFIC_TRK_IDLE;
        pend     <= 4'h0;
        win_cnt  <= '0;
        synced   <= 1'b0;
        sent_one <= 1'b0;
        lost_evt <= 1'b0;
      end else begin
        lost_evt <= 1'b0;
        if (!sync_on || elig == 4'h0) begin
          trk      <= VFIC_TRK_IDLE;
          pend     <= 4'h0;
          win_cnt  <= '0;
          synced   <= 1'b0;
          sent_one <= 1'b0;
        end else begin
          case (trk)
            VFIC_TRK_IDLE: begin
              win_cnt <= '0;
              if (next_pend == elig) begin
                synced   <= 1'b1;
                sent_one <= 1'b1;
                pend     <= 4'h0;
              end else if (next_pend != 4'h0) begin
                pend <= next_pend;
                trk  <= VFIC_TRK_COLLECT;
              end
            end
            VFIC_TRK_COLLECT: begin
              if (next_pend == elig) begin
                synced   <= 1'b1;
                sent_one <= 1'b1;
                pend     <= 4'h0;
                trk      <= VFIC_TRK_IDLE;
              end else if (win_cnt == CW'(SYNC_WIN_CYC - 1)) begin
                synced   <= 1'b0;
                lost_evt <= sent_one;
                pend     <= 4'h0;
                trk      <= VFIC_TRK_IDLE;
              end else begin
                pend    <= next_pend;
                win_cnt <= win_cnt + 1'b1;
              end
            end
            default: begin
              trk <= VFIC_TRK_IDLE;
            end
          endcase
        end
      end
    end

    // A loss in the cycle of the clearing read is kept
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        lost_flag <= 1'b0;
      end else if (lost_evt) begin
        lost_flag <= 1'b1;
      end else if (rd_sts) begin
        lost_flag <= 1'b0;
      end
    end
  end

  assign port_send = g_out[0].grant | g_out[1].grant;
  assign forwarding_status   = {4'h0, g_out[1].lost_flag, g_out[0].lost_flag,
                      g_out[1].synced_vis, g_out[0].synced_vis};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out0_fwd <= '0;
      out1_fwd <= '0;
    end else begin
      out0_fwd <= g_out[0].next_fwd;
      if (fwd_two[`VFIC_BIT_REPLICATE]) begin
        out1_fwd <= g_out[0].next_fwd;
      end else begin
        out1_fwd <= g_out[1].next_fwd;
      end
    end
  end

  // Interrupt flags: set beats every clear source
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_flag <= 6'h00;
    end else begin
      irq_flag <= ({tx_irq_event, rx_irq_event})
                | (irq_flag & ~{tx_isr_read, rx_status_read}
                            & ~irq_clr);
    end
  end

  assign irq_sts = {|(irq_flag & irq_ctl[5:0]), 1'b0, irq_flag};
  assign irq     = irq_sts[`VFIC_BIT_INT] && irq_ctl[`VFIC_BIT_INT_EN];

endmodule : vfic_core

// ---- dv/vfic_core_asserts.sv ----
// Port-level assertions for the forwarding and interrupt control block
module vfic_core_asserts
  import vfic_pkg::*;
(
  input wire logic       hclk,           // Clock
  input wire logic       hresetn,        // Reset, active low
  input wire logic       hsel,           // Slave select
  input wire logic [1:0] htrans,         // Transfer type
  input wire logic       hwrite,         // Write strobe
  input wire logic [31:0] hrdata,        // Read data
  input wire logic       hreadyout,      // Slave ready
  input wire logic       hresp,          // Response
  input wire logic [3:0] port_pkt_ready, // Packet waiting
  input wire logic [3:0] port_send,      // Packet taken
  input wire logic [1:0] out_accept,     // Output can take
  input vfic_fwd_t       out0_fwd,       // Command, output 0
  input vfic_fwd_t       out1_fwd,       // Command, output 1
  input wire logic [3:0] rx_irq_event,   // Receive events
  input wire logic [1:0] tx_irq_event,   // Transmit events
  input wire logic [3:0] rx_status_read, // Receive reads
  input wire logic [1:0] tx_isr_read,    // Transmit reads
  input wire logic       irq             // Interrupt out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not OKAY");
  chk_rdata_high: assert property (hrdata[31:8] == 24'h0) else $error("read data upper bits set");
  chk_send_ready: assert property ((port_send & ~port_pkt_ready) == 4'h0)
    else $error("grant to a port without a packet");
  chk_send_accept: assert property (out_accept == 2'b00 |-> port_send == 4'h0)
    else $error("grant with no output accepting");
  chk_send_fwd: assert property (|port_send |=> out0_fwd.valid || out1_fwd.valid)
    else $error("grant without forward command");
  chk_fwd_ports: assert property (out0_fwd.valid |-> out0_fwd.ports != 4'h0 &&
    (out0_fwd.ports & ~$past(port_send)) == 4'h0) else $error("forward ports not granted");
  // Enable or mask writes land two edges after their address phase
  chk_irq_rise: assert property ($rose(irq) |-> $past(|{rx_irq_event, tx_irq_event}) ||
    $past(hsel && htrans[1] && hwrite, 2)) else $error("interrupt rose without cause");
  chk_irq_fall: assert property ($fell(irq) |-> $past(|{rx_status_read, tx_isr_read}) ||
    $past(hsel && htrans[1] && hwrite, 2)) else $error("interrupt fell without cause");
endmodule : vfic_core_asserts

bind vfic_core vfic_core_asserts u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hrdata,
  .hreadyout, .hresp, .port_pkt_ready, .port_send, .out_accept, .out0_fwd, .out1_fwd,
  .rx_irq_event, .tx_irq_event, .rx_status_read, .tx_isr_read, .irq);

// ---- dv/vfic_partner.sv ----
// Receive-side model: each asked port offers packets, withdrawing one once taken
module vfic_partner (
  input  wire logic       hclk,           // Clock
  input  wire logic       hresetn,        // Reset, active low
  input  wire logic [3:0] want,           // Ports asked to offer
  input  wire logic [3:0] want_long,      // Offers are video lines
  input  wire logic [3:0] port_send,      // Packets taken
  output logic      [3:0] port_pkt_ready, // Packet waiting
  output logic      [3:0] port_pkt_long   // Waiting packet is a line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] taken;
  // Next packet needs a cycle to arrive, so a port is never granted twice in a row
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) taken <= 4'h0;
    else taken <= port_send;
  end
  assign port_pkt_ready = want & ~taken;
  assign port_pkt_long  = want_long & port_pkt_ready;
endmodule : vfic_partner

// ---- dv/video_forwarding_and_irq_control_tb_top.sv ----
// Register-driven bench for the forwarding and interrupt control block
`include "vfic_defs.svh"
module video_forwarding_and_irq_control_tb_top
  import vfic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] A1 = {`VFIC_IDX_FWD_CTL_ONE, 2'b00};
  localparam logic [9:0] A2 = {`VFIC_IDX_FWD_CTL_TWO, 2'b00};
  localparam logic [9:0] AS = {`VFIC_IDX_FWD_STATUS, 2'b00};
  localparam logic [9:0] AC = {`VFIC_IDX_IRQ_CTL, 2'b00};
  localparam logic [9:0] AI = {`VFIC_IDX_IRQ_STS, 2'b00};
  localparam logic [9:0] AX = {`VFIC_IDX_IRQ_CLR, 2'b00};
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [9:0]  haddr;
  logic [1:0]  htrans, out_accept, tx_irq_event, tx_isr_read;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, q;
  logic [3:0]  port_pkt_ready, port_pkt_long, port_frame_end, port_send;
  logic [3:0]  rx_irq_event, rx_status_read, want, want_long;
  vfic_fwd_t   out0_fwd, out1_fwd;
  int          mismatches, n_tests;

  vfic_core #(.SYNC_WIN_CYC(8)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .port_pkt_ready, .port_pkt_long,
    .port_frame_end, .port_send, .out_accept, .out0_fwd, .out1_fwd, .rx_irq_event,
    .rx_status_read, .tx_irq_event, .tx_isr_read, .irq);
  vfic_partner u_rx (.hclk, .hresetn, .want, .want_long, .port_send, .port_pkt_ready,
    .port_pkt_long);

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic wrap_up;
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
  endtask : wait_rdy

  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    hsize  <= `VFIC_HSIZE_WORD;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    q = hrdata;
  endtask : xfer

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), {24'h0, e}, q);
  endtask : rd

  // Looks at the grant settled after this edge, then moves to the next edge
  task automatic ps(input logic [3:0] e);
    #1;
    chk("port_send", {28'h0, e}, {28'h0, port_send});
    @(posedge hclk);
  endtask : ps

  task automatic fe(input logic [3:0] p, input int gap);
    port_frame_end <= p;
    @(posedge hclk);
    port_frame_end <= 4'h0;
    repeat (gap) @(posedge hclk);
  endtask : fe

  initial begin
    {hsel, hwrite, haddr, htrans, hsize, hwdata, out_accept, tx_irq_event} = '0;
    {tx_isr_read, port_frame_end, rx_irq_event, rx_status_read, want, want_long} = '0;
    mismatches = 0;
    n_tests = 0;
    hresetn = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(A1, `VFIC_RST_FWD_CTL_ONE);
    rd(A2, `VFIC_RST_FWD_CTL_TWO);
    rd(AC, 8'h00);
    rd(AS, 8'h00);
    rd(10'h3FC, 8'h00);
    wr(A1, 8'h00);
    want <= 4'hF;
    out_accept <= 2'b01;
    for (int i = 0; i < 4; i++) ps(4'h1 << i);
    out_accept <= 2'b00;
    wr(A1, 8'hF0);
    wr(A1, 8'hFA);
    wr(A1, 8'h0A);
    out_accept <= 2'b11;
    for (int i = 0; i < 4; i++) begin
      #1;
      chk("out0 ports", 32'h0, {28'h0, out0_fwd.ports & 4'hA});
      chk("out1 ports", 32'h0, {28'h0, out1_fwd.ports & 4'h5});
      if (i > 0) chk("out0 valid", 32'h1, 32'(out0_fwd.valid));
      if (i > 0) chk("out1 valid", 32'h1, 32'(out1_fwd.valid));
      @(posedge hclk);
    end
    wr(A1, 8'hFA);
    for (int i = 0; i < 3; i++) ps(4'h0);
    wr(A1, 8'hF0);
    wr(A1, 8'h00);
    wr(A2, 8'h83);
    @(posedge hclk);
    for (int i = 0; i < 4; i++) begin
      #1;
      chk("replica", {24'h0, out0_fwd}, {24'h0, out1_fwd});
      if (i > 0) chk("out0 valid", 32'h1, 32'(out0_fwd.valid));
      @(posedge hclk);
    end
    out_accept <= 2'b01;
    want <= 4'h0;
    wr(A2, 8'h00);
    wr(A1, 8'hC0);
    wr(A2, 8'h04);
    want <= 4'h1;
    repeat (3) ps(4'h0);
    want <= 4'h3;
    ps(4'h3);
    want <= 4'h0;
    wr(A2, 8'h44);
    want <= 4'h1;
    want_long <= 4'h1;
    ps(4'h1);
    want_long <= 4'h0;
    #1;
    chk("out0 cmd", {24'h0, 1'b1, 4'h1, 1'b1, VFIC_SYNC_BASIC}, {24'h0, out0_fwd});
    @(posedge hclk);
    ps(4'h0);
    want <= 4'h0;
    wr(A2, 8'h4C);
    want <= 4'h1;
    want_long <= 4'h1;
    repeat (2) ps(4'h0);
    {want, want_long} <= 8'h00;
    wr(A2, 8'h04);
    fe(4'h1, 12);
    rd(AS, 8'h00);
    fe(4'h3, 2);
    rd(AS, 8'h01);
    fe(4'h1, 12);
    rd(AS, 8'h04);
    rd(AS, 8'h00);
    fe(4'h3, 2);
    rd(AS, 8'h01);
    wr(A2, 8'h00);
    rd(AS, 8'h00);
    rx_irq_event <= 4'h4;
    @(posedge hclk);
    rx_irq_event <= 4'h0;
    rd(AI, 8'h04);
    wr(AC, 8'h04);
    rd(AI, 8'h84);
    chk("irq", 32'h0, 32'(irq));
    wr(AC, 8'hFF);
    rd(AC, 8'hBF);
    chk("irq", 32'h1, 32'(irq));
    rx_status_read <= 4'h4;
    @(posedge hclk);
    rx_status_read <= 4'h0;
    rd(AI, 8'h00);
    chk("irq", 32'h0, 32'(irq));
    {tx_irq_event, rx_irq_event} <= 6'h21;
    @(posedge hclk);
    {tx_irq_event, rx_irq_event} <= 6'h00;
    wr(AX, 8'h01);
    rd(AI, 8'hA0);
    tx_isr_read <= 2'h2;
    @(posedge hclk);
    tx_isr_read <= 2'h0;
    rd(AI, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(A2, 8'(m * 8'h14));
      rd(A2, 8'(m * 8'h14));
    end
    wrap_up();
  end
endmodule : video_forwarding_and_irq_control_tb_top
